// File: src/tsap_top.sv
`timescale 1ns/1ns
`default_nettype none
module tsap_top
   import tsap_pkg::*;
(
   // Clock and reset.
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite slave.
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Shelf status pins.
   input  wire tsap_pins_t        pins,
   // Alarm outputs.
   output tsap_lamps_t            lamps,
   output logic                   audible_alarm,
   output logic [2:0]             relay_energise,
   output logic                   aco_shelf_out,
   // Reference input cards.
   output logic [2*N_REF-1:0]     ref_cfg,
   output logic [N_REF-1:0]       source_online_lamp,
   output logic [N_REF-1:0]       cc_lamp,
   output logic [N_REF-1:0]       ds1_lamp,
   output logic                   phase_xfer,
   output logic [1:0]             clk_src,
   // Clock cards.
   output logic [1:0]             holdover,
   output logic [1:0]             free_run,
   output logic                   active_clk,
   // Output cards.
   output tsap_osrc_t             out_src,
   output logic [N_OUT-1:0]       clk_lamp,
   output logic [N_OUT-1:0]       input_lamp,
   output logic [N_OUT-1:0]       out_fail_lamp,
   output logic [N_OUT-1:0]       out_mute,
   output logic [N_OUT-1:0]       port_alarm_lamp,
   // Protection matrix.
   output logic [N_OUT-1:0]       matrix_relay,
   output logic [N_SPARE-1:0]     spare_online,
   output logic [OPT_W-1:0]       spare_options,
   output logic                   option_copy
);

   logic [PW-1:0]     s1, s2, s3, st, st_d;
   tsap_pins_t        p, pd;
   logic [31:0]       ctrl_reg, option_reg;
   logic [ADDR_W-1:0] waddr_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic              wr_go;
   logic [31:0]       status_w, prot_w;
   tsap_phase_t       ph_state;
   logic [PH_W-1:0]   ph_cnt;
   logic              online_reg, tgt_online, xfr_edge;
   logic [1:0]        tgt_src, tgt_src_q, had_ref_reg, in_ok;
   logic              tgt_online_q;
   tsap_osrc_t        osrc_next;
   logic [CNT_W-1:0]  cnt [N_OUT];
   logic [N_OUT-1:0]  palarm, trig, sel_edge;
   logic              armed_reg, prot_on, prot_spare, arm_edge;
   logic [IDX_W-1:0]  prot_card, trig_idx, sel_idx;
   logic              spare_pick, spare_avail, sw_go, rel_go;
   logic [IDX_W-1:0]  sw_card;
   logic              crit_c, maj_c, min_c, any_alarm, aco_edge, aco_act;
   logic [1:0]        bat_sev, fuse_sev;

   // Three-stage capture; a bit moves when stages two and three agree.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1   <= '0;
         s2   <= '0;
         s3   <= '0;
         st   <= '0;
         st_d <= '0;
      end else begin
         s1   <= pins;
         s2   <= s1;
         s3   <= s2;
         st   <= (s2 & ~(s2 ^ s3)) | (st & (s2 ^ s3));
         st_d <= st;
      end
   end
   assign p  = tsap_pins_t'(st);
   assign pd = tsap_pins_t'(st_d);

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   // Write channel: address and data taken in either order.
   assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         waddr_q       <= '0;
         wdata_q       <= '0;
         wstrb_q       <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            waddr_q       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (waddr_q[ADDR_W-1:2] == OFF_CTRL[ADDR_W-1:2] ||
                             waddr_q[ADDR_W-1:2] == OFF_OPTION[ADDR_W-1:2])
                            ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg   <= CTRL_RST;
         option_reg <= OPTION_RST;
      end else if (wr_go) begin
         if (waddr_q[ADDR_W-1:2] == OFF_CTRL[ADDR_W-1:2]) begin
            ctrl_reg <= merge(ctrl_reg, wdata_q, wstrb_q) & CTRL_MASK;
         end
         if (waddr_q[ADDR_W-1:2] == OFF_OPTION[ADDR_W-1:2]) begin
            option_reg <= merge(option_reg, wdata_q, wstrb_q) & OPTION_MASK;
         end
      end
   end

   always_comb begin
      status_w = '0;
      status_w[ST_ALARM_LSB +: 4] = {lamps.critical, lamps.major,
                                     lamps.minor, lamps.alarm_cutoff};
      status_w[ST_REF_LSB +: 5]   = {p.ref_fail, online_reg, clk_src};
      status_w[ST_CLK_LSB +: 7]   = {p.clk_fail, holdover, free_run,
                                     active_clk};
      status_w[ST_OUT_LSB +: 2 + N_OUT] = {out_src, palarm};
      prot_w = '0;
      prot_w[3:0] = {armed_reg, prot_spare, prot_card, prot_on};
   end

   // Read channel, answered one cycle after the address is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= RESP_OKAY;
         unique case (s_axi_araddr[ADDR_W-1:2])
            OFF_CTRL[ADDR_W-1:2]:   s_axi_rdata <= ctrl_reg;
            OFF_OPTION[ADDR_W-1:2]: s_axi_rdata <= option_reg;
            OFF_STATUS[ADDR_W-1:2]: s_axi_rdata <= status_w;
            OFF_PROT[ADDR_W-1:2]:   s_axi_rdata <= prot_w;
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // transfer press or on-line card failure
   assign xfr_edge = |(p.ref_xfr & ~pd.ref_xfr);
   always_comb begin
      tgt_online = online_reg;
      if (xfr_edge) begin
         tgt_online = ~online_reg;
      end
      if (p.ref_fail[online_reg] && !p.ref_fail[~online_reg]) begin
         tgt_online = ~online_reg;
      end
      tgt_src = 2'b10;
      if (p.ref_fail == 2'b01) begin
         tgt_src = 2'b11;
      end
      if (p.ref_fail == 2'b10) begin
         tgt_src = 2'b00;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ph_state     <= PH_IDLE;
         ph_cnt       <= '0;
         online_reg   <= 1'b0;
         clk_src      <= 2'b10;
         tgt_online_q <= 1'b0;
         tgt_src_q    <= 2'b10;
         phase_xfer   <= 1'b0;
      end else begin
         unique case (ph_state)
            PH_IDLE: begin
               if (tgt_online != online_reg || tgt_src != clk_src) begin
                  ph_state     <= PH_XFER;
                  ph_cnt       <= '0;
                  tgt_online_q <= tgt_online;
                  tgt_src_q    <= tgt_src;
                  phase_xfer   <= 1'b1;
               end
            end
            PH_XFER: begin
               ph_cnt <= ph_cnt + 1'b1;
               if (ph_cnt == PH_W'(PHASE_CYC - 1)) begin
                  ph_state   <= PH_IDLE;
                  online_reg <= tgt_online_q;
                  clk_src    <= tgt_src_q;
                  phase_xfer <= 1'b0;
               end
            end
         endcase
      end
   end

   // holdover or free-run per clock card
   assign in_ok[0] = !p.ref_fail[clk_src[0]];
   assign in_ok[1] = !p.ref_fail[clk_src[1]];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         had_ref_reg <= '0;
         holdover    <= '0;
         free_run    <= '0;
         active_clk  <= 1'b0;
      end else begin
         had_ref_reg <= had_ref_reg | in_ok;
         holdover    <= ~in_ok & had_ref_reg;
         free_run    <= ~in_ok & ~had_ref_reg;
         if (p.clk_fail[active_clk] && !p.clk_fail[~active_clk]) begin
            active_clk <= ~active_clk;
         end
      end
   end

   always_comb begin
      if (!p.clk_fail[0]) begin
         osrc_next = OS_CLK_A;
      end else if (!p.clk_fail[1]) begin
         osrc_next = OS_CLK_B;
      end else if (p.ref_fail != 2'b11) begin
         osrc_next = OS_REF;
      end else begin
         osrc_next = OS_NONE;
      end
   end

   always_comb begin
      for (int c = 0; c < N_OUT; c++) begin
         cnt[c] = '0;
         for (int d = 0; d < DRV; d++) begin
            cnt[c] = cnt[c] + CNT_W'(p.drv_fault[c][d]);
         end
         palarm[c] = p.out_fail[c] ||
                     (cnt[c] != '0 && cnt[c] <= MAX_BAD_DRV);
         trig[c]   = p.out_fail[c] || !p.out_present[c];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_src         <= OS_NONE;
         clk_lamp        <= '0;
         input_lamp      <= '0;
         out_fail_lamp   <= '0;
         out_mute        <= '1;
         port_alarm_lamp <= '0;
      end else begin
         out_src         <= osrc_next;
         clk_lamp        <= {N_OUT{osrc_next == OS_CLK_A ||
                                   osrc_next == OS_CLK_B}};
         input_lamp      <= {N_OUT{osrc_next == OS_REF}};
         out_fail_lamp   <= {N_OUT{osrc_next == OS_NONE}};
         out_mute        <= {N_OUT{osrc_next == OS_NONE}};
         port_alarm_lamp <= palarm;
      end
   end

   assign arm_edge = p.panel_arm && !pd.panel_arm;
   assign sel_edge = p.panel_sel & ~pd.panel_sel;
   always_comb begin
      trig_idx = '0;
      sel_idx  = '0;
      for (int c = N_OUT - 1; c >= 0; c--) begin
         if (trig[c]) begin
            trig_idx = IDX_W'(c);
         end
         if (sel_edge[c]) begin
            sel_idx = IDX_W'(c);
         end
      end
      spare_avail = |p.spare_present;
      spare_pick  = !p.spare_present[0];
      sw_go   = 1'b0;
      rel_go  = 1'b0;
      sw_card = trig_idx;
      if (p.ctrl_present) begin
         if (!prot_on) begin
            if (|trig && spare_avail) begin
               sw_go = 1'b1;
            end else if (armed_reg && |sel_edge && spare_avail) begin
               sw_go   = 1'b1;
               sw_card = sel_idx;
            end
         end else if (!p.spare_present[prot_spare] ||
                      (armed_reg && sel_edge[prot_card] &&
                       !trig[prot_card])) begin
            rel_go = 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         armed_reg     <= 1'b0;
         prot_on       <= 1'b0;
         prot_card     <= '0;
         prot_spare    <= 1'b0;
         matrix_relay  <= '0;
         spare_online  <= '0;
         spare_options <= '0;
         option_copy   <= 1'b0;
      end else begin
         option_copy <= 1'b0;
         if (arm_edge) begin
            armed_reg <= 1'b1;
         end else if (|sel_edge) begin
            armed_reg <= 1'b0;
         end
         if (sw_go) begin
            prot_on                  <= 1'b1;
            prot_card                <= sw_card;
            prot_spare               <= spare_pick;
            matrix_relay             <= '0;
            matrix_relay[sw_card]    <= 1'b1;
            spare_online             <= '0;
            spare_online[spare_pick] <= 1'b1;
            spare_options <= option_reg[OPT_W*sw_card +: OPT_W];
            option_copy   <= 1'b1;
         end else if (rel_go) begin
            prot_on      <= 1'b0;
            matrix_relay <= '0;
            spare_online <= '0;
            option_copy  <= 1'b1;
         end
      end
   end

   assign bat_sev  = p.battery_fail ? ctrl_reg[CTL_BAT_LSB +: 2] : SEV_NONE;
   assign fuse_sev = p.fuse_blown ? ctrl_reg[CTL_FUSE_LSB +: 2] : SEV_NONE;
   assign min_c = |palarm || ^p.ref_fail || ^p.clk_fail ||
                  bat_sev == SEV_MINOR || fuse_sev == SEV_MINOR;
   assign maj_c = &p.clk_fail || &p.ref_fail ||
                  bat_sev == SEV_MAJOR || fuse_sev == SEV_MAJOR;
   assign crit_c = osrc_next == OS_NONE ||
                   bat_sev == SEV_CRIT || fuse_sev == SEV_CRIT;
   assign any_alarm = crit_c || maj_c || min_c;
   assign aco_edge = (p.aco_button && !pd.aco_button) ||
                     (p.aco_remote && !pd.aco_remote) ||
                     (p.aco_shelf && !pd.aco_shelf);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aco_act        <= 1'b0;
         lamps          <= '0;
         audible_alarm  <= 1'b0;
         relay_energise <= '0;
         aco_shelf_out  <= 1'b0;
      end else begin
         if (aco_edge && any_alarm) begin
            aco_act <= 1'b1;
         end else if (!any_alarm) begin
            aco_act <= 1'b0;
         end
         lamps.critical <= crit_c;
         lamps.major    <= maj_c;
         lamps.minor    <= min_c;
         lamps.fail     <= p.mis_fail;
         lamps.alarm_cutoff      <= any_alarm && (aco_act || aco_edge);
         audible_alarm  <= any_alarm && !(aco_act || aco_edge);
         relay_energise <= {3{p.power_good}} & ~{crit_c, maj_c, min_c};
         aco_shelf_out  <= p.aco_button;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ref_cfg            <= '0;
         source_online_lamp <= '0;
         cc_lamp            <= '0;
         ds1_lamp           <= '0;
      end else begin
         ref_cfg <= ctrl_reg[CTL_REFCFG_LSB +: 2*N_REF];
         for (int r = 0; r < N_REF; r++) begin
            cc_lamp[r]  <= !ctrl_reg[CTL_REFCFG_LSB + 2*r] && !p.ref_fail[r];
            ds1_lamp[r] <= ctrl_reg[CTL_REFCFG_LSB + 2*r] && !p.ref_fail[r];
         end
         source_online_lamp <= online_reg ? 2'b10 : 2'b01;
      end
   end

endmodule
`default_nettype wire

// File: shared/tsap_pkg.sv
`default_nettype none
package tsap_pkg;
   localparam int N_REF   = 2;
   localparam int N_OUT   = 2;
   localparam int N_SPARE = 2;
   localparam int DRV     = 10;
   localparam int CNT_W   = 4;
   localparam int OPT_W   = 8;
   localparam int IDX_W   = 1;
   localparam int ADDR_W  = 8;
   localparam logic [CNT_W-1:0] MAX_BAD_DRV = 4'h5;

   localparam int CLK_MHZ       = 25;
   localparam int PHASE_XFER_NS = 2000;
   localparam int PHASE_CYC     = (PHASE_XFER_NS * CLK_MHZ + 999) / 1000;
   localparam int PH_W          = 8;

   localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_OPTION = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_PROT   = 8'h0C;

   localparam logic [31:0] CTRL_RST    = 32'h0000_0006;
   localparam logic [31:0] CTRL_MASK   = 32'h0000_00FF;
   localparam logic [31:0] OPTION_RST  = 32'h0000_0000;
   localparam logic [31:0] OPTION_MASK = 32'h0000_FFFF;
   localparam int CTL_BAT_LSB    = 0;
   localparam int CTL_FUSE_LSB   = 2;
   localparam int CTL_REFCFG_LSB = 4;

   localparam int ST_ALARM_LSB = 0;
   localparam int ST_REF_LSB   = 4;
   localparam int ST_CLK_LSB   = 9;
   localparam int ST_OUT_LSB   = 16;

   localparam logic [1:0] SEV_NONE  = 2'h0;
   localparam logic [1:0] SEV_MINOR = 2'h1;
   localparam logic [1:0] SEV_MAJOR = 2'h2;
   localparam logic [1:0] SEV_CRIT  = 2'h3;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {OS_CLK_A, OS_CLK_B, OS_REF, OS_NONE} tsap_osrc_t;
   typedef enum logic {PH_IDLE, PH_XFER} tsap_phase_t;

   typedef struct packed {
      logic                        aco_button;
      logic                        aco_remote;
      logic                        aco_shelf;
      logic                        mis_fail;
      logic                        power_good;
      logic                        battery_fail;
      logic                        fuse_blown;
      logic [N_REF-1:0]            ref_fail;
      logic [N_REF-1:0]            ref_xfr;
      logic [1:0]                  clk_fail;
      logic [N_OUT-1:0]            out_fail;
      logic [N_OUT-1:0]            out_present;
      logic [N_OUT-1:0][DRV-1:0]   drv_fault;
      logic [N_SPARE-1:0]          spare_present;
      logic                        ctrl_present;
      logic                        panel_arm;
      logic [N_OUT-1:0]            panel_sel;
   } tsap_pins_t;

   typedef struct packed {
      logic critical;
      logic major;
      logic minor;
      logic fail;
      logic alarm_cutoff;
   } tsap_lamps_t;

   localparam int PW = $bits(tsap_pins_t);
endpackage
`default_nettype wire

// File: verif/tsap_shelf_model.sv
`timescale 1ns/1ns
`default_nettype none
module tsap_shelf_model
   import tsap_pkg::*;
(
   // Clock and pacing.
   input  wire logic       aclk,
   input  wire logic       slow,
   // Wanted and driven levels.
   input  wire tsap_pins_t want,
   output tsap_pins_t      pins
);
   tsap_pins_t held;
   always_ff @(posedge aclk) begin
      held <= want;
      pins <= slow ? held : want;
   end
endmodule
`default_nettype wire

// File: verif/tsap_properties.sv
`timescale 1ns/1ns
`default_nettype none
module tsap_checker
   import tsap_pkg::*;
(
   // Clock and reset.
   input wire logic             aclk,
   input wire logic             aresetn,
   // Watched ports.
   input wire tsap_pins_t       pins,
   input wire tsap_lamps_t      lamps,
   input wire logic             audible_alarm,
   input wire logic [2:0]       relay_energise,
   input wire logic             phase_xfer,
   input wire logic [N_REF-1:0] source_online_lamp,
   input wire logic [N_OUT-1:0] clk_lamp,
   input wire logic [N_OUT-1:0] input_lamp,
   input wire logic [N_OUT-1:0] out_fail_lamp,
   input wire logic [N_OUT-1:0] out_mute,
   input wire logic [N_OUT-1:0] port_alarm_lamp,
   input wire logic [N_OUT-1:0] matrix_relay,
   input wire logic [N_SPARE-1:0] spare_online,
   input wire logic             option_copy
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   aco_mute_a: assert property (lamps.alarm_cutoff |-> !audible_alarm)
      else $error("Horn on with cut-off lamp lit.");
   power_loss_a: assert property ((!pins.power_good)[*8] |-> !relay_energise)
      else $error("Relay energised without power.");
   phase_len_a: assert property ($rose(phase_xfer) |-> ##[49:51] $fell(phase_xfer))
      else $error("Phase hand-over length wrong.");
   phase_hold_a: assert property (phase_xfer |-> $stable(source_online_lamp))
      else $error("Source moved during hand-over.");
   mute_fail_a: assert property ((out_fail_lamp & (clk_lamp | input_lamp | ~out_mute)) == 0)
      else $error("Failed card not dark and muted.");
   one_sub_a: assert property ($onehot0(matrix_relay) && $onehot0(spare_online))
      else $error("More than one substitution.");
   copy_opt_a: assert property ($changed(matrix_relay) |-> option_copy)
      else $error("Switch without option copy.");
   no_ctrl_a: assert property ((!pins.ctrl_present)[*8] |=> $stable(matrix_relay))
      else $error("Switch without controller.");
   port_minor_a: assert property (|port_alarm_lamp |-> ##[0:2] lamps.minor)
      else $error("Port alarm without minor alarm.");
   both_clk_a: assert property ((&pins.clk_fail)[*8] |-> lamps.major)
      else $error("Both clock cards failed, no major.");
   cover property ($rose(phase_xfer));
   cover property ($rose(|matrix_relay));
   cover property ($rose(lamps.alarm_cutoff));
endmodule
bind tsap_top tsap_checker i_chk (.aclk, .aresetn, .pins, .lamps,
   .audible_alarm, .relay_energise, .phase_xfer, .source_online_lamp,
   .clk_lamp, .input_lamp, .out_fail_lamp, .out_mute, .port_alarm_lamp,
   .matrix_relay, .spare_online, .option_copy);
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
   import tsap_pkg::*;
   logic aclk = 0, aresetn = 0, aw = 0, w = 0, br = 0, ar = 0, rr = 0;
   logic [ADDR_W-1:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rd_d, opt, c;
   logic awr, wr_r, bv, arr, rv, aud, px, aso;
   logic [1:0] bre, rre, mrel, spon, mute;
   logic [2:0] rel;
   logic [7:0] sopt;
   logic [33:0] qv[$];
   logic [31:0] qm[$];
   tsap_pins_t want, pins;
   int n_fail = 0, samples_checked = 0, cyc = 0;
   tsap_shelf_model i_shelf (.aclk(aclk), .slow(cyc[9]), .want(want),
      .pins(pins));
   tsap_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
      .s_axi_awvalid(aw), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(w), .s_axi_wready(wr_r),
      .s_axi_bresp(bre), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_araddr(ara), .s_axi_arvalid(ar), .s_axi_arready(arr),
      .s_axi_rdata(rd_d), .s_axi_rresp(rre), .s_axi_rvalid(rv),
      .s_axi_rready(rr), .pins(pins), .lamps(), .audible_alarm(aud),
      .relay_energise(rel), .aco_shelf_out(aso), .ref_cfg(),
      .source_online_lamp(), .cc_lamp(), .ds1_lamp(), .phase_xfer(px),
      .clk_src(), .holdover(), .free_run(), .active_clk(), .out_src(),
      .clk_lamp(), .input_lamp(), .out_fail_lamp(), .out_mute(mute),
      .port_alarm_lamp(), .matrix_relay(mrel), .spare_online(spon),
      .spare_options(sopt), .option_copy());
   always #20 aclk = ~aclk;
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [33:0] g, e);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      logic ad, wdn;
      ad = 0;
      wdn = 0;
      qv.push_back({r, 32'h0});
      qm.push_back(32'h0);
      awa <= a; wd <= d; aw <= 1; w <= 1; br <= 1;
      while (!(ad && wdn)) begin
         @(posedge aclk);
         if (awr) begin ad = 1; aw <= 0; end
         if (wr_r) begin wdn = 1; w <= 0; end
      end
      do @(posedge aclk); while (!bv);
      br <= 0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, e,
                     input logic [1:0] r = RESP_OKAY);
      qv.push_back({r, e});
      qm.push_back(m);
      ara <= a; ar <= 1; rr <= 1;
      do @(posedge aclk); while (!arr);
      ar <= 0;
      do @(posedge aclk); while (!rv);
      rr <= 0;
      @(posedge aclk);
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin n_fail++; summarize(); end
      if ((rv && rr) || (bv && br))
         chk({rv ? rre : bre, rd_d & qm.pop_front()}, qv.pop_front());
   end
   initial begin
      want = '0;
      want.power_good = 1; want.ctrl_present = 1;
      want.out_present = 2'b11; want.spare_present = 2'b01;
      opt = $urandom(32'h5fe7d550);
      opt = $urandom;
      wt(20); aresetn <= 1; wt(8);
      rd(OFF_CTRL, '1, CTRL_RST);
      rd(OFF_OPTION, '1, OPTION_RST);
      rd(8'h10, '1, 32'h0, RESP_SLVERR);
      wr(OFF_STATUS, 32'h0, RESP_SLVERR);
      wr(OFF_OPTION, opt, RESP_OKAY);
      rd(OFF_OPTION, '1, opt & OPTION_MASK);
      rd(OFF_STATUS, 32'h000F_C00F, 32'h0);
      for (int i = 0; i < 8; i++) begin
         c = i[2] ? 32'(i % 4) * 4 : 32'(i % 4);
         wr(OFF_CTRL, c, RESP_OKAY);
         want.battery_fail <= !i[2]; want.fuse_blown <= i[2]; wt(12);
         rd(OFF_STATUS, 32'hE, i % 4 == 0 ? 0 : 32'h1 << (i % 4));
      end
      wr(OFF_CTRL, 32'h0000_0004, RESP_OKAY); want.battery_fail <= 0;
      for (int k = 0; k < 3; k++) begin
         want.fuse_blown <= 1; wt(12);
         chk(aud, 1);
         {want.aco_button, want.aco_remote, want.aco_shelf} <= 3'b100 >> k;
         wt(12);
         chk(aso, k == 0);
         {want.aco_button, want.aco_remote, want.aco_shelf} <= 0;
         rd(OFF_STATUS, 32'h1, 32'h1);
         chk(aud, 0);
         want.fuse_blown <= 0; wt(12);
         rd(OFF_STATUS, 32'h1, 32'h0);
      end
      want.ref_fail <= 1;
      while (!px) @(posedge aclk);
      wt(80); rd(OFF_STATUS, 32'h70, 32'h70);
      want.ref_fail <= 0; wt(80); rd(OFF_STATUS, 32'h30, 32'h20);
      want.ref_xfr <= 1; wt(8); want.ref_xfr <= 0; wt(80);
      rd(OFF_STATUS, 32'h40, 32'h0);
      want.ref_fail <= 3; wt(80);
      rd(OFF_STATUS, 32'h3004, 32'h3004);
      want.ref_fail <= 0; wt(80); rd(OFF_STATUS, 32'h3000, 32'h0);
      want.clk_fail <= 3; wt(12);
      rd(OFF_STATUS, 32'h000C_C004, 32'h0008_C004);
      want.ref_fail <= 3; wt(80);
      rd(OFF_STATUS, 32'h000C_0008, 32'h000C_0008);
      chk(mute, 3);
      want.ref_fail <= 0; want.clk_fail <= 0; wt(80);
      want.out_fail <= 1; wt(12);
      chk({mrel, spon, sopt}, {4'h5, opt[7:0]});
      want.out_fail <= 3; wt(12);
      chk(mrel, 1);
      rd(OFF_STATUS, 32'h3_0002, 32'h3_0002);
      want.out_fail <= 0; want.spare_present <= 0; wt(12);
      chk(mrel, 0);
      for (int n = 5; n < 7; n++) begin
         want.drv_fault[1] <= (10'h1 << n) - 10'h1; wt(12);
         rd(OFF_STATUS, 32'h2_0000, n == 5 ? 32'h2_0000 : 0);
      end
      want.spare_present <= 1; want.panel_sel <= 2; wt(12);
      chk(mrel, 0);
      want.panel_sel <= 0; want.panel_arm <= 1; wt(12);
      want.panel_sel <= 2; wt(12);
      chk({mrel, spon, sopt}, {4'h9, opt[15:8]});
      want.panel_arm <= 0; want.panel_sel <= 0; wt(12);
      want.panel_arm <= 1; wt(12);
      want.panel_sel <= 2; wt(12);
      chk(mrel, 0);
      want.panel_arm <= 0; want.panel_sel <= 0; wt(12);
      want.spare_present <= 1; want.ctrl_present <= 0; want.out_fail <= 1;
      wt(20); chk(mrel, 0);
      want.power_good <= 0; wt(12);
      chk(rel, 0);
      summarize();
   end
endmodule
`default_nettype wire
